/* hdl/dlcc_params.svh */
`ifndef DLCC_PARAMS_SVH
`define DLCC_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DLCC_PADDR_W          12
`define DLCC_IDX_MODE         10'h005
`define DLCC_IDX_BG_START_X   10'h006
`define DLCC_IDX_BG_START_Y   10'h007
`define DLCC_IDX_RENDER_CFG   10'h008
`define DLCC_IDX_KEY          10'h009
`define DLCC_IDX_STATUS       10'h00a

// ****************************************************************
// Field positions
// ****************************************************************
`define DLCC_MODE_AVG_BIT     15
`define DLCC_MODE_WRAP_BIT    11
`define DLCC_MODE_BGCMB_BIT   10
`define DLCC_MODE_SYNC_LSB    6
`define DLCC_MODE_SCM_LSB     4
`define DLCC_MODE_RATE_LSB    0
`define DLCC_MODE_RW_MASK     16'h8cff
`define DLCC_RCFG_MWX_BIT     0
`define DLCC_RCFG_CDE_BIT     1
`define DLCC_STAT_LEVEL_LSB   0
`define DLCC_STAT_HAZARD_BIT  4

// ****************************************************************
// Reset values and geometry
// ****************************************************************
`define DLCC_RST_SYNC         2'b10
`define DLCC_RST_RATE         4'b1000
`define DLCC_RST_WORD16       16'h0000
`define DLCC_ORIGIN_LSB       9
`define DLCC_WRAP_Y_BITS      9
`define DLCC_WRAP_X_NARROW    10
`define DLCC_WRAP_X_WIDE      11
`define DLCC_COORD_W          14
`define DLCC_PIX_W            16
`define DLCC_FIFO_DEPTH       4

`endif

/* hdl/dlcc_pkg.sv */
`default_nettype none

package dlcc_pkg;

    typedef enum logic [2:0] {
        DLCC_REG_NONE   = 3'b000,
        DLCC_REG_MODE   = 3'b001,
        DLCC_REG_BGX    = 3'b010,
        DLCC_REG_BGY    = 3'b011,
        DLCC_REG_RCFG   = 3'b100,
        DLCC_REG_KEY    = 3'b101,
        DLCC_REG_STATUS = 3'b110
    } dlcc_reg_e;

    typedef struct packed {
        logic        avg_en;
        logic        wrap_en;
        logic        bg_combine;
        logic [1:0]  sync_mode;
        logic [1:0]  screen_combine_mode;
        logic [3:0]  rate;
        logic [15:0] bg_start_x;
        logic [15:0] bg_start_y;
        logic        memory_x_width;
        logic        cde;
        logic [15:0] key;
        logic        hazard;
        logic [31:0] prdata;
        logic        pslverr;
        logic [13:0] bg_addr_x;
        logic [13:0] bg_addr_y;
    } dlcc_state_s;

endpackage

`default_nettype wire

/* hdl/dlcc_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module dlcc_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic [WIDTH-1:0]            head;
        logic                        head_valid;
    } dlcc_fifo_s;

    dlcc_fifo_s st;
    dlcc_fifo_s next_st;
    logic [AW:0] level;

    // Head word is a register so the consumer never sees a memory mux
    assign level         = st.count + {{AW{1'b0}}, st.head_valid};
    assign level_out     = level;
    assign in_ready_out  = (level < DEPTH[AW:0]);
    assign out_valid_out = st.head_valid;
    assign out_data_out  = st.head;

    always_comb begin
        next_st = st;
        if (st.head_valid && out_ready_in) begin
            next_st.head_valid = 1'b0;
        end
        if (!next_st.head_valid && st.count != '0) begin
            next_st.head       = st.mem[st.rd_ptr];
            next_st.head_valid = 1'b1;
            next_st.rd_ptr     = st.rd_ptr + 1'b1;
            next_st.count      = st.count - 1'b1;
        end
        if (in_valid_in && in_ready_out) begin
            if (!next_st.head_valid) begin
                next_st.head       = in_data_in;
                next_st.head_valid = 1'b1;
            end else begin
                next_st.mem[st.wr_ptr] = in_data_in;
                next_st.wr_ptr         = st.wr_ptr + 1'b1;
                next_st.count          = next_st.count + 1'b1;
            end
        end
        if (!rst_n_in) begin
            next_st = '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        st <= next_st;
    end

endmodule

`default_nettype wire

/* hdl/dlcc_top.sv */
// Operation
// - Reset clears wrap, combine; sync 10, rate 1000
// - Reset keeps screen combination mode bits
// - Average off: layers leave as separate screens
// - Average on: averaged pixel leaves as foreground
// - Sum 5:6:5 components, shift right, drop fraction
// - Transparency tested on average, not foreground
// - No wrap: address passes straight through
// - Wrap X at memory width, Y at 512
// - Wrap origin from start bits 13 to 9; the code takes the X origin from start bits 13 to 10 or 13 to 11
// - Combine bit gates background into display
//
// Local design decision: the APB interface to the registers.
`include "dlcc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module dlcc_top (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [15:0] fg_pixel_in,
    input  wire logic [15:0] bg_pixel_in,
    input  wire logic        pixel_valid_in,
    output logic             pixel_ready_out,
    input  wire logic [13:0] bg_coord_x_in,
    input  wire logic [13:0] bg_coord_y_in,
    output logic [13:0]      bg_addr_x_out,
    output logic [13:0]      bg_addr_y_out,
    output logic [15:0]      fg_pixel_out,
    output logic [15:0]      bg_pixel_out,
    output logic             fg_transparent_out,
    output logic             bg_show_out,
    output logic             pixel_valid_out,
    input  wire logic        pixel_ready_in,
    output logic [1:0]       sync_mode_out,
    output logic [1:0]       screen_combine_mode_out,
    output logic [3:0]       rate_out
);
    localparam int FIFO_W = 2 * `DLCC_PIX_W + 2;

    dlcc_pkg::dlcc_state_s st;
    dlcc_pkg::dlcc_state_s next_st;

    dlcc_pkg::dlcc_reg_e   hit;
    logic                  setup_phase;
    logic                  access_wr;
    logic                  access_rd;
    logic [13:0]           sum_x;
    logic [13:0]           sum_y;
    logic [15:0]           avg_pixel;
    logic [15:0]           fg_sel;
    logic [FIFO_W-1:0]     fifo_in_data;
    logic [FIFO_W-1:0]     fifo_out_data;
    logic [2:0]            fifo_level;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic dlcc_pkg::dlcc_reg_e dlcc_decode(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        if (addr[1:0] != 2'b00) begin
            return dlcc_pkg::DLCC_REG_NONE;
        end
        case (idx)
            `DLCC_IDX_MODE:       return dlcc_pkg::DLCC_REG_MODE;
            `DLCC_IDX_BG_START_X: return dlcc_pkg::DLCC_REG_BGX;
            `DLCC_IDX_BG_START_Y: return dlcc_pkg::DLCC_REG_BGY;
            `DLCC_IDX_RENDER_CFG: return dlcc_pkg::DLCC_REG_RCFG;
            `DLCC_IDX_KEY:        return dlcc_pkg::DLCC_REG_KEY;
            `DLCC_IDX_STATUS:     return dlcc_pkg::DLCC_REG_STATUS;
            default:              return dlcc_pkg::DLCC_REG_NONE;
        endcase
    endfunction

    function automatic logic [15:0] dlcc_mode_word(input dlcc_pkg::dlcc_state_s s);
        logic [15:0] w;
        w = `DLCC_RST_WORD16;
        w[`DLCC_MODE_AVG_BIT]                           = s.avg_en;
        w[`DLCC_MODE_WRAP_BIT]                          = s.wrap_en;
        w[`DLCC_MODE_BGCMB_BIT]                         = s.bg_combine;
        w[`DLCC_MODE_SYNC_LSB+1:`DLCC_MODE_SYNC_LSB]    = s.sync_mode;
        w[`DLCC_MODE_SCM_LSB+1:`DLCC_MODE_SCM_LSB]      = s.screen_combine_mode;
        w[`DLCC_MODE_RATE_LSB+3:`DLCC_MODE_RATE_LSB]    = s.rate;
        return w;
    endfunction

    // Per-component mean: the carry is kept, the low bit falls away
    function automatic logic [15:0] dlcc_avg565(input logic [15:0] a, input logic [15:0] b);
        logic [5:0] r;
        logic [6:0] g;
        logic [5:0] bl;
        r  = {1'b0, a[15:11]} + {1'b0, b[15:11]};
        g  = {1'b0, a[10:5]} + {1'b0, b[10:5]};
        bl = {1'b0, a[4:0]} + {1'b0, b[4:0]};
        return {r[5:1], g[6:1], bl[5:1]};
    endfunction

    // ****************************************************************
    // Register bus
    // ****************************************************************
    assign hit         = dlcc_decode(paddr_in);
    assign setup_phase = psel_in && !penable_in;
    assign access_wr   = psel_in && penable_in && pwrite_in;
    assign access_rd   = psel_in && penable_in && !pwrite_in;
    // Zero wait states
    assign pready_out  = psel_in && penable_in;
    assign prdata_out  = st.prdata;
    assign pslverr_out = pready_out && st.pslverr;

    // ****************************************************************
    // Pixel path
    // ****************************************************************
    assign avg_pixel = dlcc_avg565(fg_pixel_in, bg_pixel_in);
    assign fg_sel    = st.avg_en ? avg_pixel : fg_pixel_in;

    // Key compare runs on whatever leaves as the foreground screen
    assign fifo_in_data = {fg_sel,
                           st.avg_en ? 16'h0000 : bg_pixel_in,
                           st.cde && (fg_sel == st.key),
                           st.bg_combine && !st.avg_en};

    dlcc_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (`DLCC_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (pixel_valid_in),
        .in_data_in    (fifo_in_data),
        .in_ready_out  (pixel_ready_out),
        .out_valid_out (pixel_valid_out),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (pixel_ready_in),
        .level_out     (fifo_level)
    );

    assign fg_pixel_out       = fifo_out_data[FIFO_W-1:`DLCC_PIX_W+2];
    assign bg_pixel_out       = fifo_out_data[`DLCC_PIX_W+1:2];
    assign fg_transparent_out = fifo_out_data[1];
    assign bg_show_out        = fifo_out_data[0];

    assign sync_mode_out           = st.sync_mode;
    assign screen_combine_mode_out = st.screen_combine_mode;
    assign rate_out                = st.rate;
    assign bg_addr_x_out           = st.bg_addr_x;
    assign bg_addr_y_out           = st.bg_addr_y;

    assign sum_x = st.bg_start_x[13:0] + bg_coord_x_in;
    assign sum_y = st.bg_start_y[13:0] + bg_coord_y_in;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;

        if (setup_phase) begin
            next_st.pslverr = (hit == dlcc_pkg::DLCC_REG_NONE);
            case (hit)
                dlcc_pkg::DLCC_REG_MODE:   next_st.prdata = {16'h0000, dlcc_mode_word(st)};
                dlcc_pkg::DLCC_REG_BGX:    next_st.prdata = {16'h0000, st.bg_start_x};
                dlcc_pkg::DLCC_REG_BGY:    next_st.prdata = {16'h0000, st.bg_start_y};
                dlcc_pkg::DLCC_REG_RCFG:   next_st.prdata = {30'h0, st.cde, st.memory_x_width};
                dlcc_pkg::DLCC_REG_KEY:    next_st.prdata = {16'h0000, st.key};
                dlcc_pkg::DLCC_REG_STATUS: next_st.prdata = {27'h0, st.hazard, 1'b0, fifo_level};
                default:                   next_st.prdata = 32'h0000_0000;
            endcase
        end

        // Reading status clears the hazard flag; a new hazard wins
        if (access_rd && hit == dlcc_pkg::DLCC_REG_STATUS) begin
            next_st.hazard = 1'b0;
        end

        if (access_wr) begin
            case (hit)
                dlcc_pkg::DLCC_REG_MODE: begin
                    next_st.avg_en     = pwdata_in[`DLCC_MODE_AVG_BIT];
                    next_st.wrap_en    = pwdata_in[`DLCC_MODE_WRAP_BIT];
                    next_st.bg_combine = pwdata_in[`DLCC_MODE_BGCMB_BIT];
                    next_st.sync_mode  = pwdata_in[`DLCC_MODE_SYNC_LSB+1:`DLCC_MODE_SYNC_LSB];
                    next_st.screen_combine_mode        = pwdata_in[`DLCC_MODE_SCM_LSB+1:`DLCC_MODE_SCM_LSB];
                    next_st.rate       = pwdata_in[`DLCC_MODE_RATE_LSB+3:`DLCC_MODE_RATE_LSB];
                    // Mid-stream changes glitch the picture; flag them to software
                    if (pixel_valid_in) begin
                        next_st.hazard = 1'b1;
                    end
                end
                dlcc_pkg::DLCC_REG_BGX:  next_st.bg_start_x = pwdata_in[15:0];
                dlcc_pkg::DLCC_REG_BGY:  next_st.bg_start_y = pwdata_in[15:0];
                dlcc_pkg::DLCC_REG_RCFG: begin
                    next_st.memory_x_width = pwdata_in[`DLCC_RCFG_MWX_BIT];
                    next_st.cde = pwdata_in[`DLCC_RCFG_CDE_BIT];
                end
                dlcc_pkg::DLCC_REG_KEY:  next_st.key = pwdata_in[15:0];
                default: ;
            endcase
        end

        // Background fetch address
        if (st.wrap_en) begin
            next_st.bg_addr_y = {st.bg_start_y[13:`DLCC_ORIGIN_LSB],
                                 sum_y[`DLCC_WRAP_Y_BITS-1:0]};
            if (st.memory_x_width) begin
                next_st.bg_addr_x = {st.bg_start_x[13:`DLCC_WRAP_X_WIDE],
                                     sum_x[`DLCC_WRAP_X_WIDE-1:0]};
            end else begin
                next_st.bg_addr_x = {st.bg_start_x[13:`DLCC_WRAP_X_NARROW],
                                     sum_x[`DLCC_WRAP_X_NARROW-1:0]};
            end
        end else begin
            // Running past installed memory simply aliases; contents undefined
            next_st.bg_addr_x = sum_x;
            next_st.bg_addr_y = sum_y;
        end

        if (!rst_n_in) begin
            next_st.avg_en     = 1'b0;
            next_st.wrap_en    = 1'b0;
            next_st.bg_combine = 1'b0;
            next_st.sync_mode  = `DLCC_RST_SYNC;
            next_st.rate       = `DLCC_RST_RATE;
            next_st.screen_combine_mode        = st.screen_combine_mode;
            next_st.bg_start_x = `DLCC_RST_WORD16;
            next_st.bg_start_y = `DLCC_RST_WORD16;
            next_st.memory_x_width        = 1'b0;
            next_st.cde        = 1'b0;
            next_st.key        = `DLCC_RST_WORD16;
            next_st.hazard     = 1'b0;
            next_st.prdata     = 32'h0000_0000;
            next_st.pslverr    = 1'b0;
            next_st.bg_addr_x  = 14'h0000;
            next_st.bg_addr_y  = 14'h0000;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        st <= next_st;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Unknown until the first mode write
    logic scm_written;

    always_ff @(posedge sys_clk_in) begin
        if (access_wr && hit == dlcc_pkg::DLCC_REG_MODE) begin
            scm_written <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_mode_write;
        access_wr && hit == dlcc_pkg::DLCC_REG_MODE;
    endsequence

    sequence s_mode_read;
        psel_in && !penable_in && !pwrite_in && hit == dlcc_pkg::DLCC_REG_MODE
        ##1 psel_in && penable_in;
    endsequence

    property p_reset_values;
        disable iff (1'b0)
        !rst_n_in |=> !st.wrap_en && !st.bg_combine && sync_mode_out == 2'b10
                      && rate_out == 4'b1000;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("mode reset values wrong");

    property p_scm_kept;
        disable iff (1'b0)
        (!rst_n_in && scm_written) |=> screen_combine_mode_out == $past(screen_combine_mode_out);
    endproperty
    a_scm_kept: assert property (p_scm_kept) else $error("combine mode lost in reset");

    property p_split_layers;
        pixel_valid_in && !st.avg_en |-> fifo_in_data[FIFO_W-1:2] == {fg_pixel_in, bg_pixel_in};
    endproperty
    a_split_layers: assert property (p_split_layers) else $error("layers not passed apart");

    property p_average;
        pixel_valid_in && st.avg_en |->
            fifo_in_data[FIFO_W-1:FIFO_W-5] == 5'((fg_pixel_in[15:11] + 6'(bg_pixel_in[15:11])) / 2)
            && fifo_in_data[FIFO_W-6:FIFO_W-11] == 6'((fg_pixel_in[10:5] + 7'(bg_pixel_in[10:5])) / 2)
            && fifo_in_data[FIFO_W-12:2+`DLCC_PIX_W] == 5'((fg_pixel_in[4:0] + 6'(bg_pixel_in[4:0])) / 2)
            && fifo_in_data[`DLCC_PIX_W+1:2] == 16'h0000;
    endproperty
    a_average: assert property (p_average) else $error("average pixel wrong");

    property p_transparent_on_average;
        pixel_valid_in && st.avg_en && st.cde && fg_pixel_in == st.key && avg_pixel != st.key
        |-> !fifo_in_data[1];
    endproperty
    a_transparent_on_average: assert property (p_transparent_on_average) else $error("key on fg");

    property p_no_wrap;
        !st.wrap_en |=> bg_addr_x_out == 14'($past(st.bg_start_x[13:0]) + $past(bg_coord_x_in))
                        && bg_addr_y_out == 14'($past(st.bg_start_y[13:0]) + $past(bg_coord_y_in));
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("unwrapped address wrong");

    property p_wrap_window;
        st.wrap_en && !st.memory_x_width ##1 st.wrap_en |->
            bg_addr_y_out[13:9] == $past(st.bg_start_y[13:9])
            && bg_addr_x_out[13:10] == $past(st.bg_start_x[13:10])
            && bg_addr_y_out[8:0] == 9'($past(bg_coord_y_in) + $past(st.bg_start_y[13:0]));
    endproperty
    a_wrap_window: assert property (p_wrap_window) else $error("wrap window wrong");

    property p_bg_combine;
        pixel_valid_in |-> fifo_in_data[0] == (st.bg_combine && !st.avg_en);
    endproperty
    a_bg_combine: assert property (p_bg_combine) else $error("background combine wrong");

    property p_hazard_flag;
        access_wr && hit == dlcc_pkg::DLCC_REG_MODE && pixel_valid_in |=> st.hazard;
    endproperty
    a_hazard_flag: assert property (p_hazard_flag) else $error("hazard not flagged");

    property p_mode_readback;
        s_mode_write ##1 (!psel_in) [*1] ##1 s_mode_read
        |-> prdata_out[15:0] == ($past(pwdata_in[15:0], 3) & `DLCC_MODE_RW_MASK);
    endproperty
    a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");

endmodule

`default_nettype wire

/* tb/dlcc_host.sv */
`timescale 1ns/10ps
`default_nettype none

module dlcc_host (
    input  wire logic        sys_clk_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in,
    input  wire logic [31:0] prdata_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [11:0]      paddr_out,
    output logic [31:0]      pwdata_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h00000000;
    end

    // Request held unchanged until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge sys_clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge sys_clk_in);
        penable_out <= 1'b1;
        do
            @(posedge sys_clk_in);
        while (pready_in !== 1'b1);
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
    endtask

    // Only called while no pixels are offered
    task automatic set_mode(input logic [15:0] m);
        logic [31:0] q;
        logic        e;
        m[14:12] = 3'b000;
        if (m[15]) begin
            m[5:4] = 2'b11;
            xfer(1'b1, 12'h01c, 32'h1, q, e);
        end
        xfer(1'b1, 12'h014, {16'h0000, m}, q, e);
    endtask
endmodule

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic        sys_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic        pixel_valid_in, pixel_ready_out, pixel_valid_out, pixel_ready_in;
    logic        fg_transparent_out, bg_show_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic [15:0] fg_pixel_in, bg_pixel_in, fg_pixel_out, bg_pixel_out, d, sx, sy, key;
    logic [13:0] bg_coord_x_in, bg_coord_y_in, bg_addr_x_out, bg_addr_y_out;
    logic [1:0]  sync_mode_out, screen_combine_mode_out;
    logic [3:0]  rate_out;
    logic        e;
    logic [33:0] exp_q[$];
    logic [15:0] lf = 16'he662;
    int          err_count = 0;
    int          checks = 0;

    dlcc_top dut (.sys_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .fg_pixel_in, .bg_pixel_in,
        .pixel_valid_in, .pixel_ready_out, .bg_coord_x_in, .bg_coord_y_in, .bg_addr_x_out,
        .bg_addr_y_out, .fg_pixel_out, .bg_pixel_out, .fg_transparent_out, .bg_show_out,
        .pixel_valid_out, .pixel_ready_in, .sync_mode_out, .screen_combine_mode_out, .rate_out);
    dlcc_host host (.sys_clk_in, .pready_in(pready_out), .pslverr_in(pslverr_out),
        .prdata_in(prdata_out), .psel_out(psel_in), .penable_out(penable_in),
        .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));

    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction

    // Expected word: fg, bg, transparent, background shown (colour check on)
    function automatic logic [33:0] pix(input logic [15:0] f, b, k, input int avg, comb);
        int          r, g, u;
        logic [15:0] o;
        r = (int'(f[15:11]) + int'(b[15:11])) / 2;
        g = (int'(f[10:5]) + int'(b[10:5])) / 2;
        u = (int'(f[4:0]) + int'(b[4:0])) / 2;
        o = avg != 0 ? {r[4:0], g[5:0], u[4:0]} : f;
        return {o, avg != 0 ? 16'h0000 : b, o == k, comb != 0 && avg == 0};
    endfunction

    function automatic logic [13:0] wrapa(input logic [15:0] s, input logic [13:0] c,
                                          input int wrap, w);
        int sum, m;
        sum = int'(s[13:0]) + int'(c);
        m = (1 << w) - 1;
        return wrap != 0 ? 14'((int'(s[13:0]) & ~m) | (sum & m)) : 14'(sum);
    endfunction

    task automatic chk_reg(input string n, input logic [31:0] x, g);
        checks++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk_px(input string n, input logic [15:0] x, g);
        checks++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Consumer holds off at first so the buffer must fill and refuse
    task automatic stream(input int avg, comb);
        logic [15:0] f, b;
        logic [33:0] x;
        int          got;
        got = 0;
        fork
            for (int i = 0; i < 12; i++) begin
                f = rnd();
                b = rnd();
                fg_pixel_in <= f[0] ? key : f;
                bg_pixel_in <= f[1] ? key : b;
                pixel_valid_in <= 1'b1;
                do
                    @(posedge sys_clk_in);
                while (pixel_ready_out !== 1'b1);
                exp_q.push_back(pix(f[0] ? key : f, f[1] ? key : b, key, avg, comb));
                // Last pair taken: stop offering
                if (i == 11) begin
                    pixel_valid_in <= 1'b0;
                end
            end
            begin
                repeat (10) @(posedge sys_clk_in);
                #1;
                chk_px("buffer level", 16'h0004, 16'(exp_q.size()));
                chk_px("ready when full", 16'h0000, {15'h0, pixel_ready_out});
                while (got < 12) begin
                    @(posedge sys_clk_in);
                    if (pixel_valid_out === 1'b1 && pixel_ready_in === 1'b1) begin
                        x = exp_q.pop_front();
                        chk_px("fg pixel", x[33:18], fg_pixel_out);
                        chk_px("bg pixel", x[17:2], bg_pixel_out);
                        chk_px("flags", {14'h0, x[1:0]}, {14'h0, fg_transparent_out, bg_show_out});
                        got++;
                    end
                    d = rnd();
                    pixel_ready_in <= got < 12 ? d[0] : 1'b0;
                end
            end
        join
    endtask

    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        #5000000;
        err_count++;
        end_of_test();
    end

    initial begin
        {rst_n_in, pixel_valid_in, pixel_ready_in, fg_pixel_in, bg_pixel_in} = '0;
        {bg_coord_x_in, bg_coord_y_in} = '0;
        repeat (20) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        host.xfer(1'b0, 12'h014, 32'h0, q, e);
        chk_reg("mode after reset", 32'h00000088, q & 32'hffffffcf);
        chk_px("sync and rate", 16'h0028, {10'h0, sync_mode_out, rate_out});
        repeat (3) begin
            d = rnd() & 16'h8cff;
            host.xfer(1'b1, 12'h014, {16'h0, d}, q, e);
            host.xfer(1'b0, 12'h014, 32'h0, q, e);
            chk_reg("mode readback", {16'h0, d}, q);
            chk_px("mode fields", {8'h0, d[7:0]}, {8'h0, sync_mode_out, screen_combine_mode_out, rate_out});
        end
        host.set_mode(16'h0c3f);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        host.xfer(1'b0, 12'h014, 32'h0, q, e);
        chk_reg("mode after second reset", 32'h000000b8, q);
        host.xfer(1'b0, 12'h03c, 32'h0, q, e);
        chk_reg("unmapped error and data", 32'h1, {q[30:0], e});
        $display("register test done");
        for (int c = 0; c < 4; c++) begin
            sx = rnd() & 16'h3fff;
            sy = rnd() & 16'h3fff;
            host.set_mode(c[0] ? 16'h0888 : 16'h0088);
            host.xfer(1'b1, 12'h020, {30'h0, 1'b1, c[1]}, q, e);
            host.xfer(1'b1, 12'h018, {16'h0, sx}, q, e);
            host.xfer(1'b1, 12'h01c, {16'h0, sy}, q, e);
            repeat (8) begin
                @(posedge sys_clk_in);
                d = rnd();
                bg_coord_x_in <= d[13:0];
                d = rnd();
                bg_coord_y_in <= d[13:0];
                @(posedge sys_clk_in);
                #1;
                chk_px("bg addr x", {2'b0, wrapa(sx, bg_coord_x_in, c[0], c[1] ? 11 : 10)}, {2'b0, bg_addr_x_out});
                chk_px("bg addr y", {2'b0, wrapa(sy, bg_coord_y_in, c[0], 9)}, {2'b0, bg_addr_y_out});
            end
        end
        $display("address test done");
        key = rnd();
        host.xfer(1'b1, 12'h024, {16'h0, key}, q, e);
        host.xfer(1'b1, 12'h020, 32'h2, q, e);
        for (int m = 0; m < 3; m++) begin
            host.set_mode(m == 2 ? 16'h8488 : (m == 1 ? 16'h0088 : 16'h0488));
            stream(m == 2, m != 1);
        end
        // Mode write while pixels are offered must raise the hazard flag
        pixel_valid_in <= 1'b1;
        host.xfer(1'b1, 12'h014, 32'h88, q, e);
        pixel_valid_in <= 1'b0;
        host.xfer(1'b0, 12'h028, 32'h0, q, e);
        chk_reg("status hazard", 32'h13, q);
        host.xfer(1'b0, 12'h028, 32'h0, q, e);
        chk_reg("status cleared", 32'h03, q);
        $display("pixel test done");
        end_of_test();
    end
endmodule

`default_nettype wire
